/* plk_lock_detect.sv */
// Lock detector, block-enable register and lock/serial-out pad control.
// Assumes all inputs are synchronous to clk_sys; ref_edge and div_edge are one-cycle edge pulses.
//
// Summary of operation
// - Lock declared after selected count of consecutive in-window divided edges.
// - Enable bit, set at reset, turns internal lock detection on or off.
// - Window type bit picks digital timer (1) or roughly 10 ns one-shot (0).
// - Duration field sets digital window from half to 64 timer cycles.
// - Frequency field sets timer rate, 00 fastest, 11 slowest.
// - Test mode runs timer clock continuously; otherwise one-shot per comparison.
// - Auto-relock makes exactly one reacquire attempt after a lock failure.
// - Pad enable low disables the lock/serial output pin entirely.
// - Pad enable and companion bit high keep the pin always driven.
// - Pad enable high, companion low: release pin on non-matching chip address.
// - Divider clock to logic enable gates divided edges into the detector.
// - Bias, pump, detector and both buffers enabled by bits 0 to 4.
`timescale 1ns/1ps
module plk_lock_detect (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire plk_pkg::plk_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog side
  input wire logic ref_edge,
  input wire logic div_edge,
  output plk_pkg::plk_analog_en_s analog_en,
  output logic [23:0] block_enable_word,
  output logic divider_clock_to_logic_enable,
  output logic lock_detected,
  output logic relock_req,
  // Serial port sharing
  input wire logic gpo_keep_on,
  input wire logic spi_active,
  input wire logic spi_addr_match,
  input wire logic sdo_data,
  output logic lock_serial_out_pin_o,
  output logic lock_serial_out_pin_oe,
  // Interrupt
  output logic irq
);
  import plk_pkg::*;

  logic [23:0] lock_detect_config;
  logic [23:0] block_enable_config;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] events;
  plk_state_e state;
  logic [CNT_W-1:0] hit_cnt;
  logic [CNT_W-1:0] target;
  logic relock_used;
  logic win_open;
  logic [7:0] win_cnt;
  logic [7:0] win_len;
  logic [2:0] presc;
  logic tick;
  logic div_gated;
  logic det_en;
  logic [7:0] idx;
  logic setup_ph;
  logic access_ph;
  logic mapped;

  assign idx = apb_req.paddr[9:2];
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0) &&
                  (idx == IDX_LOCK_CFG || idx == IDX_BLK_EN || idx == IDX_IRQ_STAT ||
                   idx == IDX_IRQ_MASK || idx == IDX_LOCK_STAT);

  // Zero wait states: read data is captured in the setup cycle.
  // Unmapped or misaligned requests read zero and write nothing, so a stray offset cannot alias a register.
  // The status snapshot includes events that are landing now, because the clear that follows would drop them.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !mapped;
      if (setup_ph && !apb_req.pwrite && mapped) begin
        case (idx)
          IDX_LOCK_CFG: prdata <= {8'h0, lock_detect_config};
          IDX_BLK_EN: prdata <= {8'h0, block_enable_config};
          IDX_IRQ_STAT: prdata <= {29'h0, irq_stat | events};
          IDX_IRQ_MASK: prdata <= {29'h0, irq_mask};
          IDX_LOCK_STAT: prdata <= {30'h0, relock_used, state == ST_LOCKED};
          default: prdata <= 32'h0;
        endcase
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_detect_config <= LOCK_CFG_RST;
      block_enable_config <= BLK_EN_RST;
      irq_mask <= IRQ_MASK_RST;
    end else if (access_ph && pready && apb_req.pwrite && mapped) begin
      case (idx)
        IDX_LOCK_CFG: lock_detect_config <= apb_req.pwdata[23:0];
        IDX_BLK_EN: block_enable_config <= apb_req.pwdata[23:0];
        IDX_IRQ_MASK: irq_mask <= apb_req.pwdata[IRQ_W-1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // A read clears the status, but an event in the same cycle still lands.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (access_ph && pready && !apb_req.pwrite && mapped && idx == IDX_IRQ_STAT) begin
        irq_stat <= events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  assign det_en = lock_detect_config[LKD_EN_BIT];
  assign div_gated = div_edge && block_enable_config[DIVCLK_BIT];

  always_comb begin
    case (lock_detect_config[LKD_CNT_LSB +: 3])
      3'h0: target = 17'd5;
      3'h1: target = 17'd32;
      3'h2: target = 17'd96;
      3'h3: target = 17'd256;
      3'h4: target = 17'd512;
      3'h5: target = 17'd2048;
      3'h6: target = 17'd8192;
      default: target = 17'd65535;
    endcase
  end

  // The window counter counts half timer cycles, so code 0 gives half a cycle.
  assign win_len = lock_detect_config[WIN_TYPE_BIT] ?
                   (8'h1 << lock_detect_config[WIN_DUR_LSB +: 3]) : ONESHOT_CYC;
  assign tick = (presc == 3'((4'h1 << lock_detect_config[TMR_FREQ_LSB +: 2]) - 4'h1));

  // Prescaler restarts at each reference edge unless test mode runs it freely.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      presc <= 3'h0;
    end else if (lock_detect_config[TMR_TEST_BIT]) begin
      presc <= tick ? 3'h0 : presc + 3'h1;
    end else if (ref_edge || !win_open || tick) begin
      presc <= 3'h0;
    end else begin
      presc <= presc + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      win_open <= 1'b0;
      win_cnt <= 8'h0;
    end else if (ref_edge && det_en) begin
      win_open <= 1'b1;
      win_cnt <= 8'h0;
    end else if (win_open && (tick || !lock_detect_config[WIN_TYPE_BIT])) begin
      win_cnt <= win_cnt + 8'h1;
      if (win_cnt + 8'h1 >= win_len) begin
        win_open <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_OFF;
      hit_cnt <= '0;
      relock_used <= 1'b0;
      relock_req <= 1'b0;
      events <= '0;
    end else begin
      relock_req <= 1'b0;
      events <= '0;
      case (state)
        ST_OFF: begin
          hit_cnt <= '0;
          if (det_en) begin
            state <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (!det_en) begin
            state <= ST_OFF;
          end else if (div_gated && !win_open) begin
            hit_cnt <= '0;
          end else if (div_gated) begin
            hit_cnt <= hit_cnt + 17'h1;
            if (hit_cnt + 17'h1 >= target) begin
              state <= ST_LOCKED;
              relock_used <= 1'b0;
              events[IRQ_GAINED] <= 1'b1;
            end
          end
        end
        ST_LOCKED: begin
          if (!det_en) begin
            state <= ST_OFF;
          end else if (div_gated && !win_open) begin
            state <= ST_ACQ;
            hit_cnt <= '0;
            events[IRQ_LOST] <= 1'b1;
            if (lock_detect_config[RELOCK_BIT] && !relock_used) begin
              relock_req <= 1'b1;
              relock_used <= 1'b1;
              events[IRQ_RELOCK] <= 1'b1;
            end
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_detected <= 1'b0;
    end else begin
      lock_detected <= (state == ST_LOCKED);
    end
  end

  assign analog_en = plk_analog_en_s'(block_enable_config[VCOBUF_BIT:BIAS_BIT]);
  assign block_enable_word = block_enable_config;
  assign divider_clock_to_logic_enable = block_enable_config[DIVCLK_BIT];

  // Pad: serial data while this chip is addressed, otherwise the lock flag.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_serial_out_pin_o <= 1'b0;
      lock_serial_out_pin_oe <= 1'b0;
    end else begin
      lock_serial_out_pin_o <= (spi_active && spi_addr_match) ? sdo_data : (state == ST_LOCKED);
      if (!block_enable_config[PAD_EN_BIT]) begin
        lock_serial_out_pin_oe <= 1'b0;
      end else if (gpo_keep_on) begin
        lock_serial_out_pin_oe <= 1'b1;
      end else begin
        lock_serial_out_pin_oe <= !(spi_active && !spi_addr_match);
      end
    end
  end

endmodule

/* plk_pkg.sv */
// Package for the lock detector and block-enable register bank.
// Assumes one clock domain at 125 MHz and an APB master with 32-bit data.
package plk_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_LOCK_CFG = 8'h07;
  localparam logic [7:0] IDX_BLK_EN = 8'h08;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] IDX_LOCK_STAT = 8'h12;

  localparam int REG_W = 24;
  localparam logic [23:0] LOCK_CFG_RST = 24'h00014d;
  localparam logic [23:0] BLK_EN_RST = 24'hc1beff;

  // Lock detect configuration fields.
  localparam int LKD_CNT_LSB = 0;
  localparam int LKD_EN_BIT = 3;
  localparam int WIN_TYPE_BIT = 6;
  localparam int WIN_DUR_LSB = 7;
  localparam int TMR_FREQ_LSB = 10;
  localparam int TMR_TEST_BIT = 12;
  localparam int RELOCK_BIT = 13;

  // Block enable fields.
  localparam int BIAS_BIT = 0;
  localparam int PUMP_BIT = 1;
  localparam int PD_BIT = 2;
  localparam int REFBUF_BIT = 3;
  localparam int VCOBUF_BIT = 4;
  localparam int PAD_EN_BIT = 5;
  localparam int DIVCLK_BIT = 7;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 3;
  localparam int IRQ_GAINED = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_RELOCK = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Analog one-shot window, a longest time, so rounded down but kept at one cycle at least.
  localparam int CLK_MHZ = 125;
  localparam int ONESHOT_NS = 10;
  localparam int ONESHOT_RAW = (ONESHOT_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] ONESHOT_CYC = 8'((ONESHOT_RAW < 1) ? 1 : ONESHOT_RAW);

  localparam int CNT_W = 17;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ACQ = 3'b010,
    ST_LOCKED = 3'b100
  } plk_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } plk_apb_req_s;

  typedef struct packed {
    logic vco_buffer_enable;
    logic ref_buffer_enable;
    logic phase_detector_enable;
    logic pump_enable;
    logic bias_enable;
  } plk_analog_en_s;

endpackage

/* plk_lock_detect_assertions.sv */
// Concurrent checks on the ports of the lock detector bank.
// Assumes one clk_sys domain with a synchronous active-high reset.
`timescale 1ns/1ps
module plk_lock_detect_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed ports
  input wire plk_pkg::plk_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire plk_pkg::plk_analog_en_s analog_en,
  input wire logic [23:0] block_enable_word,
  input wire logic divider_clock_to_logic_enable,
  input wire logic lock_detected,
  input wire logic relock_req,
  input wire logic gpo_keep_on,
  input wire logic spi_active,
  input wire logic spi_addr_match,
  input wire logic lock_serial_out_pin_oe
);
  import plk_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  apb_answer_a: assert property (apb_req.psel && !apb_req.penable |=> pready)
    else $error("pready missing after setup");
  apb_ready_cause_a: assert property (pready |-> $past(apb_req.psel && !apb_req.penable))
    else $error("pready without setup");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  blk_map_a: assert property (analog_en == block_enable_word[4:0])
    else $error("enable bits differ from register");
  div_gate_a: assert property (divider_clock_to_logic_enable == block_enable_word[7])
    else $error("divider gate differs from register");
  pad_off_a: assert property (!block_enable_word[5] |=> !lock_serial_out_pin_oe)
    else $error("pad driven while disabled");
  pad_keep_a: assert property (block_enable_word[5] && gpo_keep_on |=> lock_serial_out_pin_oe)
    else $error("pad not kept on");
  pad_share_a: assert property (block_enable_word[5] && !gpo_keep_on && spi_active && !spi_addr_match
    |=> !lock_serial_out_pin_oe)
    else $error("pad not released");
  relock_once_a: assert property (relock_req |-> $past(lock_detected) ##1 !relock_req)
    else $error("relock pulse wrong");
endmodule

bind plk_lock_detect plk_lock_detect_assertions i_plk_lock_detect_assertions (.clk_sys, .rst, .apb_req,
  .prdata, .pready, .pslverr, .analog_en, .block_enable_word, .divider_clock_to_logic_enable,
  .lock_detected, .relock_req, .gpo_keep_on, .spi_active, .spi_addr_match, .lock_serial_out_pin_oe);

/* testbench.sv */
// Self-checking bench for the lock detector and block-enable bank.
// Drives APB, edge pulses and pad inputs itself; no partner model.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import plk_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  plk_apb_req_s apb_req = '0;
  logic ref_edge = 1'b0, div_edge = 1'b0, gpo_keep_on = 1'b0, spi_active = 1'b0;
  logic spi_addr_match = 1'b0, sdo_data = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, divider_clock_to_logic_enable, lock_detected, relock_req, irq;
  logic lock_serial_out_pin_o, lock_serial_out_pin_oe;
  logic [23:0] block_enable_word;
  plk_analog_en_s analog_en;
  int error_cnt = 0, cmp_count = 0, relock_cnt = 0;
  plk_lock_detect i_plk_lock_detect (.clk_sys, .rst, .apb_req, .prdata, .pready, .pslverr, .ref_edge,
    .div_edge, .analog_en, .block_enable_word, .divider_clock_to_logic_enable, .lock_detected,
    .relock_req, .gpo_keep_on, .spi_active, .spi_addr_match, .sdo_data, .lock_serial_out_pin_o,
    .lock_serial_out_pin_oe, .irq);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (relock_req === 1'b1) relock_cnt++;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Sample in mid-cycle: these are the values that the next rising edge takes.
    do begin
      @(negedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    q = prdata;
    e = pslverr;
    @(posedge clk_sys);
    apb_req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask
  // A true argument opens the window first; a false one sends a stray divided edge.
  // The divided edge comes gap cycles later than in the plain case; the task ends in mid-cycle.
  task automatic hit(input int k, input logic win, input int gap = 0);
    repeat (k) begin
      @(posedge clk_sys);
      ref_edge <= win;
      @(posedge clk_sys);
      ref_edge <= 1'b0;
      repeat (gap) @(posedge clk_sys);
      div_edge <= 1'b1;
      @(posedge clk_sys);
      div_edge <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    @(negedge clk_sys);
  endtask
  task automatic test_regs;
    wr(12'h41c, 32'h0);
    rdc(12'h01c, 32'h0000014d, 1'b0);
    rdc(12'h020, 32'h00c1beff, 1'b0);
    rdc(12'h030, 32'h0, 1'b1);
    rdc(12'h41d, 32'h0, 1'b1);
    `CHK(analog_en, 5'h1f)
    `CHK(divider_clock_to_logic_enable, 1'b1)
    wr(12'h020, 32'hffc1bee0);
    @(negedge clk_sys);
    `CHK(analog_en, 5'h00)
    `CHK(block_enable_word, 24'hc1bee0)
    rdc(12'h020, 32'h00c1bee0, 1'b0);
    wr(12'h020, 32'h00c1beff);
    $display("test_regs done");
  endtask
  task automatic test_lock;
    wr(12'h044, 32'h7);
    wr(12'h01c, 32'h2008);
    hit(4, 1'b1);
    `CHK(lock_detected, 1'b0)
    hit(1, 1'b1);
    `CHK(lock_detected, 1'b1)
    `CHK(irq, 1'b1)
    hit(1, 1'b0);
    `CHK(lock_detected, 1'b0)
    hit(1, 1'b0);
    `CHK(relock_cnt, 1)
    rdc(12'h040, 32'h7, 1'b0);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wr(12'h044, 32'h0);
    hit(5, 1'b1);
    hit(1, 1'b0);
    `CHK(irq, 1'b0)
    `CHK(relock_cnt, 2)
    rdc(12'h040, 32'h7, 1'b0);
    rdc(12'h048, 32'h2, 1'b0);
    $display("test_lock done");
  endtask
  task automatic test_gate;
    wr(12'h01c, 32'h2000);
    hit(6, 1'b1);
    `CHK(lock_detected, 1'b0)
    wr(12'h01c, 32'h2008);
    wr(12'h020, 32'h00c1be7f);
    hit(6, 1'b1);
    `CHK(lock_detected, 1'b0)
    wr(12'h020, 32'h00c1beff);
    $display("test_gate done");
  endtask
  // Digital window of four ticks: open for four edges at the fastest rate, eight at the next rate.
  task automatic test_window;
    wr(12'h01c, 32'h148);
    hit(5, 1'b1, 3);
    `CHK(lock_detected, 1'b1)
    hit(1, 1'b1, 4);
    `CHK(lock_detected, 1'b0)
    `CHK(relock_cnt, 2)
    wr(12'h01c, 32'h548);
    hit(5, 1'b1, 7);
    `CHK(lock_detected, 1'b1)
    hit(1, 1'b1, 8);
    `CHK(lock_detected, 1'b0)
    wr(12'h01c, 32'h1548);
    hit(5, 1'b1, 5);
    `CHK(lock_detected, 1'b1)
    hit(1, 1'b1, 8);
    `CHK(lock_detected, 1'b0)
    $display("test_window done");
  endtask
  task automatic test_pad;
    wr(12'h020, 32'h00c1bedf);
    gpo_keep_on <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(lock_serial_out_pin_oe, 1'b0)
    wr(12'h020, 32'h00c1beff);
    repeat (2) @(posedge clk_sys);
    `CHK(lock_serial_out_pin_oe, 1'b1)
    gpo_keep_on <= 1'b0;
    spi_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(lock_serial_out_pin_oe, 1'b0)
    `CHK(lock_serial_out_pin_o, 1'b0)
    spi_addr_match <= 1'b1;
    sdo_data <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(lock_serial_out_pin_oe, 1'b1)
    `CHK(lock_serial_out_pin_o, 1'b1)
    $display("test_pad done");
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    test_regs();
    test_lock();
    test_gate();
    test_window();
    test_pad();
    finish_test();
  end
endmodule
